// file: hdl/edt_translator.sv
// Purpose: drive select, gate logic and serial command handshake
// Assumes: pins are asynchronous and pass two flip-flops
// Notes: good commands queue in a fifo toward the microcontroller
// Notes on behaviour
// - match when select code equals straps
// - code zero selects no drive
// - take command bits only when selected
// - read gate out follows read gate in
// - write gate out blocked by write protect
// - both gates at once flag write fault
// - command is sixteen bits plus parity
// - acknowledge once the bit is captured
// - seventeen state bit counter
// - shift pulse on request while selected
// - counter holds at sixteen or captured
// - reply load starts shifting out, clears capture
// - upper byte first register, lower second
// - any captured command returns reply on reply load
// - attention on any fault or external
// - reset attention command clears write fault
// - odd parity good raises command ready
// - link fault when transfer aborted early
`timescale 1ns/100ps
`include "edt_regs.svh"

module edt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o = mem[rd_q[AW-1:0]];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

module edt_translator
    import edt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [2:0] drive_sel_i,
    input wire logic [2:0] drive_id_straps_i,
    input wire logic read_gate_i,
    input wire logic write_gate_i,
    input wire logic write_protect_i,
    input wire logic cmd_data_i,
    input wire logic xfer_req_i,
    input wire logic external_fault_in_i,
    output logic xfer_ack_o,
    output logic reply_data_o,
    output logic read_gate_o,
    output logic write_gate_o,
    output logic attention_o,
    output logic drive_match_flag_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic [15:0] cmd_word_o,
    input wire logic reply_load_i,
    input wire logic [15:0] reply_word_i,
    input wire logic cmd_done_i,
    output logic command_complete_o,
    output logic command_capture_done_o,
    output logic reply_shift_active_o,
    output logic count_lsb_o,
    output logic count_at_sixteen_o,
    output logic transfer_in_progress_o,
    output logic write_conflict_fault_o,
    output logic parity_fault_o,
    output logic link_fault_o
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [`EDT_SYNC_W-1:0] sync1_q;
    logic [`EDT_SYNC_W-1:0] sync2_q;
    logic [2:0] dsel_s;
    logic [2:0] straps_s;
    logic rg_s, wg_s, wp_s, bit_s, req_s, ext_s;
    logic match_q;
    edt_mode_e mode_q;
    edt_hs_e hs_q;
    logic [`EDT_CNT_W-1:0] cnt_q;
    logic [7:0] ra_q;
    logic [7:0] rb_q;
    logic par_q;
    logic busy_q;
    logic tx_bit_q;
    logic done_q;
    logic wr_flt_q, par_flt_q, link_flt_q;
    logic rg_q, wg_q, att_q;
    logic fifo_rdy;
    logic take_ok;
    logic shift;
    logic last;
    logic par_ok;
    logic push;
    logic abort;
    logic conflict;
    logic [15:0] sr;

    function automatic logic is_reset_cmd(input logic [15:0] w);
        is_reset_cmd = w[`EDT_FN_HI:`EDT_FN_LO] == `EDT_FN_CONTROL &&
                       w[`EDT_MOD_HI:`EDT_MOD_LO] == `EDT_MOD_RESET;
    endfunction

    // reset release through two flops
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // pin synchroniser
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {drive_sel_i, drive_id_straps_i, read_gate_i, write_gate_i,
                        write_protect_i, cmd_data_i, xfer_req_i, external_fault_in_i};
            sync2_q <= sync1_q;
        end
    end
    assign {dsel_s, straps_s, rg_s, wg_s, wp_s, bit_s, req_s, ext_s} = sync2_q;

    assign sr = {ra_q, rb_q};
    assign last = cnt_q == `EDT_CNT_LAST;
    assign take_ok = mode_q != EDT_MODE_HOLD && !(mode_q == EDT_MODE_RX && last && !fifo_rdy);
    assign shift = match_q && req_s && hs_q == EDT_HS_IDLE && take_ok;
    assign par_ok = par_q ^ bit_s;
    assign push = shift && mode_q == EDT_MODE_RX && last && par_ok;
    assign abort = busy_q && !match_q;
    assign conflict = rg_s && wg_s;

    // selection, gates and attention
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= 1'b0;
            rg_q <= 1'b0;
            wg_q <= 1'b0;
            att_q <= 1'b0;
        end else begin
            match_q <= dsel_s == straps_s && dsel_s != 3'h0;
            rg_q <= rg_s;
            wg_q <= wg_s && !wp_s;
            att_q <= wr_flt_q || par_flt_q || link_flt_q || ext_s || conflict;
        end
    end

    // bit handshake
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            hs_q <= EDT_HS_IDLE;
        end else begin
            case (hs_q)
                EDT_HS_IDLE: begin
                    if (shift) begin
                        hs_q <= EDT_HS_ACK;
                    end
                end
                EDT_HS_ACK: begin
                    if (!req_s) begin
                        hs_q <= EDT_HS_IDLE;
                    end
                end
                default: hs_q <= EDT_HS_IDLE;
            endcase
        end
    end

    // counter, data registers and parity
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= EDT_MODE_RX;
            cnt_q <= '0;
            ra_q <= 8'h00;
            rb_q <= 8'h00;
            par_q <= 1'b0;
            busy_q <= 1'b0;
            tx_bit_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                mode_q <= EDT_MODE_RX;
                cnt_q <= '0;
                par_q <= 1'b0;
                busy_q <= 1'b0;
            end else begin
                case (mode_q)
                    EDT_MODE_RX: begin
                        if (shift) begin
                            par_q <= par_q ^ bit_s;
                            busy_q <= !last;
                            if (!last) begin
                                {ra_q, rb_q} <= {sr[14:0], bit_s};
                                cnt_q <= cnt_q + 1'b1;
                            end else if (par_ok) begin
                                mode_q <= EDT_MODE_HOLD;
                            end else begin
                                cnt_q <= '0;
                                par_q <= 1'b0;
                            end
                        end
                    end
                    EDT_MODE_HOLD: begin
                        if (reply_load_i) begin
                            mode_q <= EDT_MODE_TX;
                            {ra_q, rb_q} <= reply_word_i;
                            tx_bit_q <= reply_word_i[15];
                            cnt_q <= '0;
                            par_q <= 1'b0;
                        end else if (cmd_done_i) begin
                            mode_q <= EDT_MODE_RX;
                            cnt_q <= '0;
                            par_q <= 1'b0;
                            done_q <= 1'b1;
                        end
                    end
                    EDT_MODE_TX: begin
                        if (shift) begin
                            busy_q <= !last;
                            if (last) begin
                                mode_q <= EDT_MODE_RX;
                                cnt_q <= '0;
                                par_q <= 1'b0;
                                done_q <= 1'b1;
                            end else begin
                                {ra_q, rb_q} <= {sr[14:0], 1'b0};
                                par_q <= par_q ^ sr[15];
                                cnt_q <= cnt_q + 1'b1;
                                tx_bit_q <= cnt_q == `EDT_CNT_PRE ? !(par_q ^ sr[15]) : sr[14];
                            end
                        end
                    end
                    default: mode_q <= EDT_MODE_RX;
                endcase
            end
        end
    end

    // fault flags, set wins over clear
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_flt_q <= 1'b0;
            par_flt_q <= 1'b0;
            link_flt_q <= 1'b0;
        end else begin
            if (conflict) begin
                wr_flt_q <= 1'b1;
            end else if (push && is_reset_cmd(sr)) begin
                wr_flt_q <= 1'b0;
            end
            if (shift && mode_q == EDT_MODE_RX && last && !par_ok) begin
                par_flt_q <= 1'b1;
            end else if (push && is_reset_cmd(sr)) begin
                par_flt_q <= 1'b0;
            end
            if (abort) begin
                link_flt_q <= 1'b1;
            end else if (push && is_reset_cmd(sr)) begin
                link_flt_q <= 1'b0;
            end
        end
    end

    edt_fifo #(
        .WIDTH(`EDT_WORD_W),
        .DEPTH(`EDT_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_n),
        .in_valid_i(push),
        .in_ready_o(fifo_rdy),
        .in_data_i(sr),
        .out_valid_o(cmd_valid_o),
        .out_ready_i(cmd_ready_i),
        .out_data_o(cmd_word_o)
    );

    assign xfer_ack_o = hs_q == EDT_HS_ACK;
    assign reply_data_o = tx_bit_q;
    assign read_gate_o = rg_q;
    assign write_gate_o = wg_q;
    assign attention_o = att_q;
    assign drive_match_flag_o = match_q;
    assign command_complete_o = done_q;
    assign command_capture_done_o = mode_q == EDT_MODE_HOLD;
    assign reply_shift_active_o = mode_q == EDT_MODE_TX;
    assign count_lsb_o = cnt_q[0];
    assign count_at_sixteen_o = last;
    assign transfer_in_progress_o = busy_q;
    assign write_conflict_fault_o = wr_flt_q;
    assign parity_fault_o = par_flt_q;
    assign link_fault_o = link_flt_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    a_match_compare: assert property (##1 match_q == $past(dsel_s == straps_s && dsel_s != 3'h0))
        else $error("drive match wrong");
    a_wgate_protect: assert property (write_gate_o |-> $past(wg_s) && !$past(wp_s))
        else $error("write gate passed under protect");
    a_rgate_follow: assert property (##1 read_gate_o == $past(rg_s))
        else $error("read gate not following");
    a_conflict_atten: assert property (conflict |=> attention_o && write_conflict_fault_o)
        else $error("gate conflict not flagged");
    a_no_shift_unsel: assert property (!match_q && !xfer_ack_o |=> !xfer_ack_o)
        else $error("ack raised while not selected");
    a_ack_after_shift: assert property (shift |=> xfer_ack_o)
        else $error("no ack after capture");
    a_ack_holds: assert property (xfer_ack_o && req_s |=> xfer_ack_o)
        else $error("ack dropped under request");
    a_cnt_bound: assert property (cnt_q <= `EDT_CNT_LAST)
        else $error("counter past sixteen");
    a_hold_count: assert property (mode_q == EDT_MODE_HOLD && !reply_load_i && !cmd_done_i && !abort
        |=> $stable(cnt_q) && mode_q == EDT_MODE_HOLD)
        else $error("counter moved while captured");
    a_reply_enter: assert property (mode_q == EDT_MODE_HOLD && reply_load_i && !abort
        |=> reply_shift_active_o && cnt_q == 5'h00 && !command_capture_done_o)
        else $error("reply not started");
    a_link_fault: assert property (abort |=> link_fault_o && !transfer_in_progress_o)
        else $error("abort not flagged");
    a_reset_cmd: assert property (push && is_reset_cmd(sr) && !conflict |=> !write_conflict_fault_o)
        else $error("reset command kept write fault");
endmodule

// file: inc/edt_regs.svh
// Purpose: shared constants of the drive command translator
// Assumes: included by bare name
// Notes: definitions only
`ifndef EDT_REGS_SVH
`define EDT_REGS_SVH
`define EDT_CNT_W 5
`define EDT_CNT_LAST 5'h10
`define EDT_CNT_PRE 5'h0f
`define EDT_WORD_W 16
`define EDT_FIFO_DEPTH 32
`define EDT_FN_HI 15
`define EDT_FN_LO 12
`define EDT_MOD_HI 11
`define EDT_MOD_LO 8
`define EDT_FN_CONTROL 4'h5
`define EDT_MOD_RESET 4'h0
`define EDT_SYNC_W 12
`endif

// file: inc/edt_pkg.sv
// Purpose: types of the drive command translator
// Assumes: nothing
// Notes: mode tracks capture, hold and reply phases
package edt_pkg;
    typedef enum logic [1:0] {
        EDT_MODE_RX = 2'b00,
        EDT_MODE_HOLD = 2'b01,
        EDT_MODE_TX = 2'b10
    } edt_mode_e;
    typedef enum logic {
        EDT_HS_IDLE = 1'b0,
        EDT_HS_ACK = 1'b1
    } edt_hs_e;
endpackage

// file: testbench/edt_ctrl_model.sv
// Purpose: disk controller side of the serial command link
// Assumes: drives on the falling edge of the system clock
// Notes: idle data line shows the inverse of the last bit
`timescale 1ns/100ps
module edt_ctrl_model (
    input wire logic clk_i,
    input wire logic ack_i,
    output logic req_o,
    output logic data_o
);
    initial begin
        req_o = 1'b0;
        data_o = 1'b0;
    end
    // present a bit under request, wait for acknowledge
    task automatic raise(input logic b, input int lim, output bit ok);
        int n;
        @(negedge clk_i);
        data_o = b;
        req_o = 1'b1;
        n = 0;
        while (ack_i !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        ok = (ack_i === 1'b1);
    endtask
    // release after acknowledge, wait for it to fall
    task automatic drop(input int lim, output bit ok);
        int n;
        @(negedge clk_i);
        req_o = 1'b0;
        data_o = ~data_o;
        n = 0;
        while (ack_i !== 1'b0 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        ok = (ack_i === 1'b0);
    endtask
endmodule

// file: testbench/testbench.sv
// Purpose: self-checking bench of the drive command translator
// Assumes: inputs change on the falling clock edge
// Notes: request-status code chosen freely, design does not decode it
`timescale 1ns/100ps
module testbench;
    logic clk, rst_b, rg, wg, wp, ext, pop, rl, cd, req, dat;
    logic [2:0] sel, straps;
    logic [15:0] rw, cword;
    logic ack, rdat, rgo, wgo, att, match, cval, ccomp, ccap, rsa, clsb, c16, tip, wcf, pf, lf;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_done = 0;
    edt_translator i_dut (.clk_sys_i(clk), .rst_b_i(rst_b), .drive_sel_i(sel), .drive_id_straps_i(straps),
        .read_gate_i(rg), .write_gate_i(wg), .write_protect_i(wp), .cmd_data_i(dat), .xfer_req_i(req),
        .external_fault_in_i(ext), .xfer_ack_o(ack), .reply_data_o(rdat), .read_gate_o(rgo),
        .write_gate_o(wgo), .attention_o(att), .drive_match_flag_o(match), .cmd_valid_o(cval),
        .cmd_ready_i(pop), .cmd_word_o(cword), .reply_load_i(rl), .reply_word_i(rw), .cmd_done_i(cd),
        .command_complete_o(ccomp), .command_capture_done_o(ccap), .reply_shift_active_o(rsa),
        .count_lsb_o(clsb), .count_at_sixteen_o(c16), .transfer_in_progress_o(tip),
        .write_conflict_fault_o(wcf), .parity_fault_o(pf), .link_fault_o(lf));
    edt_ctrl_model i_ctl (.clk_i(clk), .ack_i(ack), .req_o(req), .data_o(dat));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ccomp === 1'b1) begin
            n_done++;
        end
    end
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic must(input bit ok);
        if (!ok) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic xbit(input logic b);
        bit ok;
        i_ctl.raise(b, 40, ok);
        must(ok);
        i_ctl.drop(40, ok);
        must(ok);
    endtask
    task automatic send(input logic [16:0] f);
        for (int i = 16; i >= 0; i--) begin
            xbit(f[i]);
        end
    endtask
    task automatic done_pulse();
        step(1);
        cd = 1'b1;
        step(1);
        cd = 1'b0;
    endtask
    function automatic logic [16:0] frm(input logic [15:0] w);
        return {w, ~^w};
    endfunction
    initial begin
        bit ok;
        logic [16:0] e;
        rst_b = 1'b0;
        sel = 3'h0;
        straps = 3'h5;
        {rg, wg, wp, ext, pop, rl, cd} = 7'h00;
        rw = 16'h0000;
        step(20);
        rst_b = 1'b1;
        for (int s = 0; s < 8; s++) begin
            sel = s[2:0];
            step(6);
            check(match, s == 5);
        end
        straps = 3'h0;
        sel = 3'h0;
        step(6);
        check(match, 1'b0);
        straps = 3'h5;
        sel = 3'h5;
        for (int g = 0; g < 8; g++) begin
            {rg, wg, wp} = g[2:0];
            step(6);
            check(rgo, rg);
            check(wgo, wg & !wp);
            if (rg & wg) begin
                check(att, 1'b1);
            end
        end
        {rg, wg, wp} = 3'h0;
        step(6);
        check(wcf, 1'b1);
        send(frm(16'h1234) ^ 17'h1);
        step(6);
        check({pf, cval}, 2'b10);
        xbit(1'b1);
        xbit(1'b0);
        check(tip, 1'b1);
        sel = 3'h3;
        step(8);
        check(lf, 1'b1);
        i_ctl.raise(1'b1, 20, ok);
        check(ok, 1'b0);
        i_ctl.drop(20, ok);
        sel = 3'h5;
        step(6);
        send(frm(16'h5000));
        step(6);
        check({cval, cword}, {1'b1, 16'h5000});
        check({wcf, pf, lf, att}, 4'h0);
        i_ctl.raise(1'b1, 20, ok);
        check(ok, 1'b0);
        i_ctl.drop(20, ok);
        done_pulse();
        pop = 1'b1;
        step(1);
        pop = 1'b0;
        ext = 1'b1;
        step(6);
        check({cval, att}, 2'b01);
        ext = 1'b0;
        send(frm(16'h2000));
        step(4);
        pop = 1'b1;
        step(1);
        pop = 1'b0;
        rw = 16'ha5c3;
        e = frm(rw);
        rl = 1'b1;
        step(1);
        rl = 1'b0;
        step(4);
        check({rsa, ccap}, 2'b10);
        for (int i = 0; i < 17; i++) begin
            step(1);
            check(rdat, e[16-i]);
            xbit(1'b0);
            if (i < 16) begin
                check(clsb, (i + 1) % 2);
                check(c16, i == 15);
            end
        end
        step(4);
        check({rsa, n_done[1:0]}, 3'b010);
        for (int k = 0; k < 32; k++) begin
            send(frm(16'h0100 + k[15:0]));
            done_pulse();
        end
        e = frm(16'h0200);
        for (int i = 16; i > 0; i--) begin
            xbit(e[i]);
        end
        i_ctl.raise(e[0], 30, ok);
        check(ok, 1'b0);
        pop = 1'b1;
        for (int k = 0; k < 32; k++) begin
            check(cword, 16'h0100 + k[15:0]);
            step(1);
        end
        pop = 1'b0;
        i_ctl.drop(40, ok);
        must(ok);
        step(2);
        check({cval, cword}, {1'b1, 16'h0200});
        done_pulse();
        pop = 1'b1;
        step(1);
        pop = 1'b0;
        step(1);
        check(cval, 1'b0);
        complete_run();
    end
endmodule
